// ===== src/main_config_map.vh
// Register indices, byte addresses, field positions, reset values and decode constants
`ifndef MAIN_CONFIG_MAP_VH
`define MAIN_CONFIG_MAP_VH

// ======================================================================
// Register indices and byte addresses
`define IDX_STATE_BAND_TRIM      2'h0
`define IDX_MODULATION_DATAPATH  2'h1
`define IDX_DEVIATION_DIVIDER    2'h2
`define IDX_BIT_RATE_DIVIDER     2'h3
`define ADDR_LSB                 2
`define ADDR_WIDTH               8
`define ADDR_SPAN_TOP            8'h0C

// ======================================================================
// Reset values
`define RST_STATE_BAND_TRIM      8'h28
`define RST_MODULATION_DATAPATH  8'h88
`define RST_DEVIATION_DIVIDER    8'h03
`define RST_BIT_RATE_DIVIDER     8'h07
`define RST_DEVIATION_DIVISOR    14'h0080
`define RST_RATE_FIELD           7'h07
`define RST_BIT_RATE_DIVISOR     14'h0200

// ======================================================================
// Byte 0 fields
`define OP_STATE_HI              7
`define OP_STATE_LO              5
`define BAND_HI                  4
`define BAND_LO                  3
`define TUNE_HI                  2
`define TUNE_LO                  1
`define DIV_SET_BIT              0

// ======================================================================
// Byte 1 fields
`define MOD_HI                   7
`define MOD_LO                   6
`define DATA_MODE_LO_BIT         5
`define SLICER_HI                4
`define SLICER_LO                3
`define DATA_MODE_HI_BIT         2
`define GAIN_HI                  1
`define GAIN_LO                  0

// ======================================================================
// Byte 3 fields
`define RATE_RESERVED_BIT        7
`define RATE_HI                  6

// ======================================================================
// Encodings
`define OP_SLEEP                 3'h0
`define OP_STANDBY               3'h1
`define OP_SYNTH                 3'h2
`define OP_RECEIVE               3'h3
`define BAND_LOWER               2'h0
`define BAND_MIDDLE              2'h1
`define BAND_UPPER               2'h2
`define MOD_ONOFF                2'h1
`define MOD_FREQSHIFT            2'h2
`define SLICER_FIXED             2'h0
`define SLICER_PEAK              2'h1
`define SLICER_AVERAGE           2'h2
`define SLICER_RESERVED          2'h3
`define DM_CONTINUOUS            2'h0
`define DM_BUFFERED              2'h1
`define TUNE_STEP_MV             8'h3C
`define GAIN_STEP_HALF_DB        5'h09
`define DEV_SCALE_SHIFT          5
`define RATE_SCALE_SHIFT         6

// ======================================================================
// Bus responses
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// ===== src/receiver_main_config_regs.v
// Main configuration register bank of the receiver with an AXI4-Lite slave port
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "main_config_map.vh"

// Overview of operation
// R1: Byte 0 bits 7-5 pick sleep, standby (default), synthesizer or receive.
// R2: Byte 0 bits 4-3 pick lower, middle (default) or board-chosen upper band.
// R3: Byte 0 bits 2-1 add 0 (default), 60, 120 or 180 mV tune offset.
// R4: Byte 0 bit 0 picks first divider set (default) or second.
// R5: Byte 1 bits 7-6 pick on-off keying 01 or frequency-shift 10 (default).
// R6: Data mode is byte 1 bit 2 high, bit 5 low: continuous, buffered, packet.
// R7: Byte 1 bits 4-3 pick fixed, peak (default), average slicer; 11 reserved.
// R8: Byte 1 bits 1-0 give max gain or 4.5, 9, 13.5 dB reduction.
// R9: Byte 2 sets deviation as crystal over 32 times value plus one.
// R10: Byte 3 bits 6-0 set bit rate as crystal over 64 times value plus one.
// R11: Software keeps byte 3 bit 7 at 0 and avoids state codes above 011.
// R12: Every field reads back the last write and holds its default after reset.
module receiver_main_config_regs (
   // Clock and reset
   input  wire        CLK_SYS,
   input  wire        NRST,
   // AXI4-Lite write address
   input  wire [7:0]  AWADDR,
   input  wire [2:0]  AWPROT,
   input  wire        AWVALID,
   output reg         AWREADY,
   // AXI4-Lite write data
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output reg         WREADY,
   // AXI4-Lite write response
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   // AXI4-Lite read address
   input  wire [7:0]  ARADDR,
   input  wire [2:0]  ARPROT,
   input  wire        ARVALID,
   output reg         ARREADY,
   // AXI4-Lite read data
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // Operating state
   output reg  [2:0]  OP_STATE,
   output reg         STATE_SLEEP,
   output reg         STATE_STANDBY,
   output reg         STATE_SYNTH,
   output reg         STATE_RECEIVE,
   output reg         STATE_CODE_INVALID,
   // Synthesizer settings
   output reg  [1:0]  BAND_SELECT,
   output reg  [1:0]  OSCILLATOR_TUNE_OFFSET,
   output reg  [7:0]  TUNE_OFFSET_MV,
   output reg         DIVIDER_SET_SELECT,
   // Demodulator settings
   output reg  [1:0]  MODULATION_SELECT,
   output reg         MOD_IS_ONOFF,
   output reg         MOD_IS_FREQSHIFT,
   output reg  [1:0]  DATA_MODE,
   output reg         DATA_MODE_PACKET,
   output reg  [1:0]  ONOFF_SLICER_THRESHOLD_TYPE,
   output reg         SLICER_CODE_RESERVED,
   output reg  [1:0]  IF_GAIN_STEP,
   output reg  [4:0]  GAIN_CUT_HALF_DB,
   // Rate dividers
   output reg  [7:0]  DEVIATION_DIVIDER,
   output reg  [13:0] DEVIATION_DIVISOR,
   output reg  [6:0]  BIT_RATE_DIVIDER,
   output reg  [13:0] BIT_RATE_DIVISOR
);

   // ======================================================================
   // Storage
   reg  [7:0]  state_band_trim_reg;
   reg  [7:0]  modulation_datapath_reg;
   reg  [7:0]  deviation_divider_reg;
   reg  [7:0]  bit_rate_divider_reg;
   reg  [7:0]  state_band_trim_next;
   reg  [7:0]  modulation_datapath_next;
   reg  [7:0]  deviation_divider_next;
   reg  [7:0]  bit_rate_divider_next;

   // ======================================================================
   // Bus state
   reg         aw_full_reg;
   reg         w_full_reg;
   reg  [7:0]  aw_addr_reg;
   reg  [7:0]  w_data_reg;
   reg         w_lane_reg;
   reg         aw_full_next;
   reg         w_full_next;
   reg         bvalid_next;
   reg         rvalid_next;
   reg  [31:0] rdata_next;
   reg  [1:0]  rresp_next;
   reg  [1:0]  bresp_next;
   wire        aw_take;
   wire        w_take;
   wire        ar_take;
   wire        do_write;
   wire        wr_hit;
   wire        rd_hit;
   wire [1:0]  wr_idx;
   wire [1:0]  rd_idx;

   // Protection bits are accepted and ignored
   assign aw_take  = AWVALID & AWREADY;
   assign w_take   = WVALID & WREADY;
   assign ar_take  = ARVALID & ARREADY;
   assign do_write = aw_full_reg & w_full_reg & ~BVALID;
   // Off-word or past-the-end addresses get an error
   assign wr_hit   = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= `ADDR_SPAN_TOP);
   assign rd_hit   = (ARADDR[1:0] == 2'h0) && (ARADDR <= `ADDR_SPAN_TOP);
   assign wr_idx   = aw_addr_reg[`ADDR_LSB+1:`ADDR_LSB];
   assign rd_idx   = ARADDR[`ADDR_LSB+1:`ADDR_LSB];

   // ======================================================================
   // Write channel bookkeeping: address and data taken in either order
   // Store waits for both halves, so no half pairs
   // with a stale one; the response rises with it
   always @* begin
      aw_full_next = aw_full_reg | aw_take;
      w_full_next  = w_full_reg | w_take;
      if (do_write) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
      end
      bvalid_next = do_write | (BVALID & ~BREADY);
      bresp_next  = BRESP;
      if (do_write) begin
         bresp_next = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   // ======================================================================
   // Register next values; only byte lane 0 carries data
   always @* begin
      state_band_trim_next     = state_band_trim_reg;
      modulation_datapath_next = modulation_datapath_reg;
      deviation_divider_next   = deviation_divider_reg;
      bit_rate_divider_next    = bit_rate_divider_reg;
      if (do_write && wr_hit && w_lane_reg) begin
         case (wr_idx)
            `IDX_STATE_BAND_TRIM: begin
               state_band_trim_next = w_data_reg; // R12
            end
            `IDX_MODULATION_DATAPATH: begin
               modulation_datapath_next = w_data_reg; // R12
            end
            `IDX_DEVIATION_DIVIDER: begin
               deviation_divider_next = w_data_reg; // R9
            end
            `IDX_BIT_RATE_DIVIDER: begin
               // Reserved top bit is stored as written; software keeps it 0
               bit_rate_divider_next = w_data_reg; // R10 R11
            end
            default: begin
               state_band_trim_next = state_band_trim_reg;
            end
         endcase
      end
   end

   // ======================================================================
   // Read path: data is latched at the address handshake
   // Reads run apart from writes; one taken at the
   // store edge returns the byte before that write
   always @* begin
      rvalid_next = ar_take | (RVALID & ~RREADY);
      rdata_next  = RDATA;
      rresp_next  = RRESP;
      if (ar_take) begin
         rresp_next = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         rdata_next = 32'h00000000;
         if (rd_hit) begin
            case (rd_idx)
               `IDX_STATE_BAND_TRIM: begin
                  rdata_next = {24'h000000, state_band_trim_reg}; // R12
               end
               `IDX_MODULATION_DATAPATH: begin
                  rdata_next = {24'h000000, modulation_datapath_reg}; // R12
               end
               `IDX_DEVIATION_DIVIDER: begin
                  rdata_next = {24'h000000, deviation_divider_reg}; // R12
               end
               `IDX_BIT_RATE_DIVIDER: begin
                  rdata_next = {24'h000000, bit_rate_divider_reg}; // R12
               end
               default: begin
                  rdata_next = 32'h00000000;
               end
            endcase
         end
      end
   end

   // ======================================================================
   // Bus flip-flops
   // Readies are registered, so they rise one edge after reset
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         aw_full_reg             <= 1'b0;
         w_full_reg              <= 1'b0;
         aw_addr_reg             <= 8'h00;
         w_data_reg              <= 8'h00;
         w_lane_reg              <= 1'b0;
         AWREADY                 <= 1'b0;
         WREADY                  <= 1'b0;
         BVALID                  <= 1'b0;
         BRESP                   <= `RESP_OKAY;
         ARREADY                 <= 1'b0;
         RVALID                  <= 1'b0;
         RDATA                   <= 32'h00000000;
         RRESP                   <= `RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         // Each half is captured on its own handshake
         if (aw_take) begin
            aw_addr_reg <= AWADDR;
         end
         if (w_take) begin
            w_data_reg <= WDATA[7:0];
            w_lane_reg <= WSTRB[0];
         end
         // Ready drops while a half is held so the pair cannot be overrun
         AWREADY                 <= ~aw_full_next & ~bvalid_next;
         WREADY                  <= ~w_full_next & ~bvalid_next;
         BVALID                  <= bvalid_next;
         BRESP                   <= bresp_next;
         ARREADY                 <= ~rvalid_next;
         RVALID                  <= rvalid_next;
         RDATA                   <= rdata_next;
         RRESP                   <= rresp_next;
      end
   end

   // Stored bytes
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         state_band_trim_reg     <= `RST_STATE_BAND_TRIM; // R12
         modulation_datapath_reg <= `RST_MODULATION_DATAPATH; // R12
         deviation_divider_reg   <= `RST_DEVIATION_DIVIDER; // R12
         bit_rate_divider_reg    <= `RST_BIT_RATE_DIVIDER; // R12
      end else begin
         state_band_trim_reg     <= state_band_trim_next;
         modulation_datapath_reg <= modulation_datapath_next;
         deviation_divider_reg   <= deviation_divider_next;
         bit_rate_divider_reg    <= bit_rate_divider_next;
      end
   end

   // ======================================================================
   // Decoded settings, one cycle behind the stored bytes
   // Registered so every output leaves a flop
   reg  [2:0]  op_code;
   reg  [1:0]  tune_code;
   reg  [1:0]  mod_code;
   reg  [1:0]  slicer_code;
   reg  [1:0]  gain_code;
   reg  [1:0]  data_mode_next;
   reg  [7:0]  tune_mv_next;
   reg  [4:0]  gain_cut_next;
   reg  [13:0] dev_divisor_next;
   reg  [13:0] rate_divisor_next;

   always @* begin
      op_code     = state_band_trim_reg[`OP_STATE_HI:`OP_STATE_LO];
      tune_code   = state_band_trim_reg[`TUNE_HI:`TUNE_LO];
      mod_code    = modulation_datapath_reg[`MOD_HI:`MOD_LO];
      slicer_code = modulation_datapath_reg[`SLICER_HI:`SLICER_LO];
      gain_code   = modulation_datapath_reg[`GAIN_HI:`GAIN_LO];
      data_mode_next = {modulation_datapath_reg[`DATA_MODE_HI_BIT],
                        modulation_datapath_reg[`DATA_MODE_LO_BIT]}; // R6
      // 3 x 60 and 3 x 9 fit their targets
      tune_mv_next   = `TUNE_STEP_MV * {6'h00, tune_code}; // R3
      gain_cut_next  = `GAIN_STEP_HALF_DB * {3'h0, gain_code}; // R8
      // Divisor widths hold 32 x 256 and 64 x 128 exactly
      dev_divisor_next  = ({6'h00, deviation_divider_reg} + 14'h0001)
                          << `DEV_SCALE_SHIFT; // R9
      rate_divisor_next = ({7'h00, bit_rate_divider_reg[`RATE_HI:0]} + 14'h0001)
                          << `RATE_SCALE_SHIFT; // R10
   end

   // Decoded output flops; reset values match the
   // stored defaults, so nothing steps on release
   always @(posedge CLK_SYS) begin
      if (!NRST) begin
         OP_STATE                    <= `OP_STANDBY;
         STATE_SLEEP                 <= 1'b0;
         STATE_STANDBY               <= 1'b1;
         STATE_SYNTH                 <= 1'b0;
         STATE_RECEIVE               <= 1'b0;
         STATE_CODE_INVALID          <= 1'b0;
         BAND_SELECT                 <= `BAND_MIDDLE;
         OSCILLATOR_TUNE_OFFSET      <= 2'h0;
         TUNE_OFFSET_MV              <= 8'h00;
         DIVIDER_SET_SELECT          <= 1'b0;
         MODULATION_SELECT           <= `MOD_FREQSHIFT;
         MOD_IS_ONOFF                <= 1'b0;
         MOD_IS_FREQSHIFT            <= 1'b1;
         DATA_MODE                   <= `DM_CONTINUOUS;
         DATA_MODE_PACKET            <= 1'b0;
         ONOFF_SLICER_THRESHOLD_TYPE <= `SLICER_PEAK;
         SLICER_CODE_RESERVED        <= 1'b0;
         IF_GAIN_STEP                <= 2'h0;
         GAIN_CUT_HALF_DB            <= 5'h00;
         DEVIATION_DIVIDER           <= `RST_DEVIATION_DIVIDER;
         DEVIATION_DIVISOR           <= `RST_DEVIATION_DIVISOR;
         BIT_RATE_DIVIDER            <= `RST_RATE_FIELD;
         BIT_RATE_DIVISOR            <= `RST_BIT_RATE_DIVISOR;
      end else begin
         OP_STATE           <= op_code; // R1
         STATE_SLEEP        <= (op_code == `OP_SLEEP); // R1
         STATE_STANDBY      <= (op_code == `OP_STANDBY); // R1
         STATE_SYNTH        <= (op_code == `OP_SYNTH); // R1
         STATE_RECEIVE      <= (op_code == `OP_RECEIVE); // R1
         // Codes above receive select no state; flagged for software
         STATE_CODE_INVALID <= (op_code > `OP_RECEIVE); // R11
         BAND_SELECT            <= state_band_trim_reg[`BAND_HI:`BAND_LO]; // R2
         OSCILLATOR_TUNE_OFFSET <= tune_code; // R3
         TUNE_OFFSET_MV         <= tune_mv_next; // R3
         DIVIDER_SET_SELECT     <= state_band_trim_reg[`DIV_SET_BIT]; // R4
         MODULATION_SELECT      <= mod_code; // R5
         MOD_IS_ONOFF           <= (mod_code == `MOD_ONOFF); // R5
         MOD_IS_FREQSHIFT       <= (mod_code == `MOD_FREQSHIFT); // R5
         DATA_MODE              <= data_mode_next; // R6
         DATA_MODE_PACKET       <= data_mode_next[1]; // R6
         ONOFF_SLICER_THRESHOLD_TYPE <= slicer_code; // R7
         SLICER_CODE_RESERVED   <= (slicer_code == `SLICER_RESERVED); // R7
         IF_GAIN_STEP           <= gain_code; // R8
         GAIN_CUT_HALF_DB       <= gain_cut_next; // R8
         DEVIATION_DIVIDER      <= deviation_divider_reg; // R9
         DEVIATION_DIVISOR      <= dev_divisor_next; // R9
         BIT_RATE_DIVIDER       <= bit_rate_divider_reg[`RATE_HI:0]; // R10
         BIT_RATE_DIVISOR       <= rate_divisor_next; // R10
      end
   end

endmodule

// ===== verif/receiver_main_config_regs_properties.sv
// Concurrent checks on the ports of the receiver main configuration register bank
`timescale 1ns/100ps
`include "main_config_map.vh"
module receiver_main_config_regs_properties (
   // Clock and reset
   input logic        CLK_SYS,
   input logic        NRST,
   // Bus handshakes
   input logic [1:0]  BRESP,
   input logic        BVALID,
   input logic        BREADY,
   input logic        ARVALID,
   input logic        ARREADY,
   input logic [31:0] RDATA,
   input logic        RVALID,
   input logic        RREADY,
   // Decoded settings
   input logic [2:0]  OP_STATE,
   input logic        STATE_SLEEP,
   input logic        STATE_RECEIVE,
   input logic        STATE_CODE_INVALID,
   input logic [1:0]  OSCILLATOR_TUNE_OFFSET,
   input logic [7:0]  TUNE_OFFSET_MV,
   input logic [1:0]  IF_GAIN_STEP,
   input logic [4:0]  GAIN_CUT_HALF_DB,
   input logic [7:0]  DEVIATION_DIVIDER,
   input logic [13:0] DEVIATION_DIVISOR,
   input logic [6:0]  BIT_RATE_DIVIDER,
   input logic [13:0] BIT_RATE_DIVISOR
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   // ======================================================================
   // Bus timing
   read_latency_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read data did not follow the accepted address");
   read_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data changed before it was taken");
   resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response changed before it was taken");
   read_block_a: assert property (RVALID |-> !ARREADY)
      else $error("read address accepted while a read answer is pending");
   // ======================================================================
   // Field decodes; both sides are flops of the same byte, so they agree every cycle
   state_decode_a: assert property (STATE_RECEIVE |-> OP_STATE == `OP_RECEIVE)
      else $error("receive flag without receive code");
   state_valid_a: assert property (OP_STATE <= `OP_RECEIVE |-> !STATE_CODE_INVALID
      && STATE_SLEEP == (OP_STATE == `OP_SLEEP))
      else $error("state decode disagrees with state code");
   tune_mv_a: assert property (TUNE_OFFSET_MV == OSCILLATOR_TUNE_OFFSET * `TUNE_STEP_MV)
      else $error("tune offset in millivolts is wrong");
   gain_cut_a: assert property (GAIN_CUT_HALF_DB == IF_GAIN_STEP * `GAIN_STEP_HALF_DB)
      else $error("gain reduction is wrong");
   dev_div_a: assert property (DEVIATION_DIVISOR == (14'(DEVIATION_DIVIDER) + 14'h0001) << 5)
      else $error("deviation divisor is wrong");
   rate_div_a: assert property (BIT_RATE_DIVISOR == (14'(BIT_RATE_DIVIDER) + 14'h0001) << 6)
      else $error("bit rate divisor is wrong");
   cover property (BVALID && BREADY && BRESP == `RESP_SLVERR);
   cover property (RVALID && RREADY);
   cover property (STATE_RECEIVE);
endmodule

bind receiver_main_config_regs receiver_main_config_regs_properties u_props (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
   .OP_STATE(OP_STATE), .STATE_SLEEP(STATE_SLEEP), .STATE_RECEIVE(STATE_RECEIVE),
   .STATE_CODE_INVALID(STATE_CODE_INVALID), .OSCILLATOR_TUNE_OFFSET(OSCILLATOR_TUNE_OFFSET),
   .TUNE_OFFSET_MV(TUNE_OFFSET_MV), .IF_GAIN_STEP(IF_GAIN_STEP),
   .GAIN_CUT_HALF_DB(GAIN_CUT_HALF_DB), .DEVIATION_DIVIDER(DEVIATION_DIVIDER),
   .DEVIATION_DIVISOR(DEVIATION_DIVISOR), .BIT_RATE_DIVIDER(BIT_RATE_DIVIDER),
   .BIT_RATE_DIVISOR(BIT_RATE_DIVISOR));

// ===== verif/receiver_main_config_regs_tb.sv
// Self-checking bench for the receiver main configuration register bank
`timescale 1ns/100ps
`include "main_config_map.vh"
module receiver_main_config_regs_tb;
   logic        CLK_SYS, NRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic        ARVALID, ARREADY, RVALID, RREADY, STATE_SLEEP, STATE_STANDBY;
   logic        STATE_SYNTH, STATE_RECEIVE, STATE_CODE_INVALID, DIVIDER_SET_SELECT;
   logic        MOD_IS_ONOFF, MOD_IS_FREQSHIFT, DATA_MODE_PACKET, SLICER_CODE_RESERVED;
   logic [1:0]  BRESP, RRESP, BAND_SELECT, OSCILLATOR_TUNE_OFFSET, MODULATION_SELECT;
   logic [1:0]  DATA_MODE, ONOFF_SLICER_THRESHOLD_TYPE, IF_GAIN_STEP;
   logic [2:0]  AWPROT, ARPROT, OP_STATE;
   logic [3:0]  WSTRB;
   logic [4:0]  GAIN_CUT_HALF_DB;
   logic [6:0]  BIT_RATE_DIVIDER;
   logic [7:0]  AWADDR, ARADDR, TUNE_OFFSET_MV, DEVIATION_DIVIDER, b;
   logic [13:0] DEVIATION_DIVISOR, BIT_RATE_DIVISOR;
   logic [31:0] WDATA, RDATA;
   int          err_total, num_checks, ready_lag;

   receiver_main_config_regs u_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .AWADDR(AWADDR),
      .AWPROT(AWPROT), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARPROT(ARPROT), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .OP_STATE(OP_STATE),
      .STATE_SLEEP(STATE_SLEEP), .STATE_STANDBY(STATE_STANDBY), .STATE_SYNTH(STATE_SYNTH),
      .STATE_RECEIVE(STATE_RECEIVE), .STATE_CODE_INVALID(STATE_CODE_INVALID),
      .BAND_SELECT(BAND_SELECT), .OSCILLATOR_TUNE_OFFSET(OSCILLATOR_TUNE_OFFSET),
      .TUNE_OFFSET_MV(TUNE_OFFSET_MV), .DIVIDER_SET_SELECT(DIVIDER_SET_SELECT),
      .MODULATION_SELECT(MODULATION_SELECT), .MOD_IS_ONOFF(MOD_IS_ONOFF),
      .MOD_IS_FREQSHIFT(MOD_IS_FREQSHIFT), .DATA_MODE(DATA_MODE),
      .DATA_MODE_PACKET(DATA_MODE_PACKET), .SLICER_CODE_RESERVED(SLICER_CODE_RESERVED),
      .ONOFF_SLICER_THRESHOLD_TYPE(ONOFF_SLICER_THRESHOLD_TYPE), .IF_GAIN_STEP(IF_GAIN_STEP),
      .GAIN_CUT_HALF_DB(GAIN_CUT_HALF_DB), .DEVIATION_DIVIDER(DEVIATION_DIVIDER),
      .DEVIATION_DIVISOR(DEVIATION_DIVISOR), .BIT_RATE_DIVIDER(BIT_RATE_DIVIDER),
      .BIT_RATE_DIVISOR(BIT_RATE_DIVISOR));

   always #10 CLK_SYS = ~CLK_SYS;

   // ======================================================================
   // Compare, bus tasks and verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address and data are offered together; each is dropped once its ready was seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      do begin
         @(posedge CLK_SYS);
         aw_done = aw_done | AWREADY;
         w_done = w_done | WREADY;
         AWVALID <= !aw_done;
         WVALID <= !w_done;
      end while (!(aw_done && w_done));
      repeat (ready_lag) @(posedge CLK_SYS);
      BREADY <= 1'b1;
      do @(posedge CLK_SYS); while (BVALID !== 1'b1);
      BREADY <= 1'b0;
      check("write response", er, BRESP);
   endtask

   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      ARADDR <= a;
      ARVALID <= 1'b1;
      do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      repeat (ready_lag) @(posedge CLK_SYS);
      RREADY <= 1'b1;
      do @(posedge CLK_SYS); while (RVALID !== 1'b1);
      RREADY <= 1'b0;
      check(what, exp, RDATA);
      check("read response", er, RRESP);
   endtask

   task automatic chk_defaults;
      rd("byte0", 8'h00, 32'h28, `RESP_OKAY);
      rd("byte1", 8'h04, 32'h88, `RESP_OKAY);
      rd("byte2", 8'h08, 32'h03, `RESP_OKAY);
      rd("byte3", 8'h0C, 32'h07, `RESP_OKAY);
      check("standby", 1'b1, STATE_STANDBY);
      check("band", 2'h1, BAND_SELECT);
      check("tune", 2'h0, OSCILLATOR_TUNE_OFFSET);
      check("modulation", 2'h2, MODULATION_SELECT);
      check("data mode", 2'h0, DATA_MODE);
      check("slicer", 2'h1, ONOFF_SLICER_THRESHOLD_TYPE);
      check("dev divisor", 32 * 4, DEVIATION_DIVISOR);
      check("rate divisor", 64 * 8, BIT_RATE_DIVISOR);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Generous: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge CLK_SYS);
      err_total++;
      summarize();
   end

   // ======================================================================
   // Test sequence
   initial begin
      CLK_SYS = 1'b0;
      NRST <= 1'b0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 5'h00;
      {AWADDR, ARADDR, AWPROT, ARPROT, WSTRB, WDATA} <= 58'h0;
      err_total = 0;
      num_checks = 0;
      ready_lag = 0;
      repeat (12) @(posedge CLK_SYS);
      NRST <= 1'b1;
      @(posedge CLK_SYS);
      chk_defaults();
      for (int i = 0; i < 4; i++) begin
         b = {i[2:0], 2'(i % 3), 2'(3 - i), i[0]};
         wr(8'h00, {24'h0, b}, 4'h1, `RESP_OKAY);
         @(posedge CLK_SYS);
         check("state", i, OP_STATE);
         check("sleep", i == 0, STATE_SLEEP);
         check("synth", i == 2, STATE_SYNTH);
         check("receive", i == 3, STATE_RECEIVE);
         check("band", i % 3, BAND_SELECT);
         check("tune mv", (3 - i) * 60, TUNE_OFFSET_MV);
         check("div set", i % 2, DIVIDER_SET_SELECT);
         rd("byte0", 8'h00, b, `RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) begin
         b = {2'(1 + i % 2), i[0], i[1:0], i[1], i[1:0]};
         wr(8'h04, {24'h0, b}, 4'h1, `RESP_OKAY);
         @(posedge CLK_SYS);
         check("onoff", i % 2 == 0, MOD_IS_ONOFF);
         check("freqshift", i % 2 == 1, MOD_IS_FREQSHIFT);
         check("data mode", i, DATA_MODE);
         check("packet", i >= 2, DATA_MODE_PACKET);
         check("slicer", i, ONOFF_SLICER_THRESHOLD_TYPE);
         check("slicer reserved", i == 3, SLICER_CODE_RESERVED);
         check("gain cut", 9 * i, GAIN_CUT_HALF_DB);
         rd("byte1", 8'h04, b, `RESP_OKAY);
      end
      // Both ends of each divider range; bit 7 of byte 3 stays clear
      for (int j = 0; j < 2; j++) begin
         wr(8'h08, j ? 32'hFF : 32'h00, 4'h1, `RESP_OKAY);
         wr(8'h0C, j ? 32'h7F : 32'h00, 4'h1, `RESP_OKAY);
         @(posedge CLK_SYS);
         check("dev divisor", 32 * (j * 255 + 1), DEVIATION_DIVISOR);
         check("rate divisor", 64 * (j * 127 + 1), BIT_RATE_DIVISOR);
         rd("byte3", 8'h0C, j ? 32'h7F : 32'h00, `RESP_OKAY);
      end
      ready_lag = 3;
      wr(8'h10, 32'h11, 4'h1, `RESP_SLVERR);
      wr(8'h05, 32'h22, 4'h1, `RESP_SLVERR);
      wr(8'h08, 32'h33, 4'h0, `RESP_OKAY);
      rd("byte2 kept", 8'h08, 32'hFF, `RESP_OKAY);
      rd("unmapped", 8'h10, 32'h0, `RESP_SLVERR);
      rd("byte0 kept", 8'h00, 32'h61, `RESP_OKAY);
      NRST <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      NRST <= 1'b1;
      @(posedge CLK_SYS);
      chk_defaults();
      summarize();
   end
endmodule
